// ===== eepc_top.sv
// eeprom program/erase control: apb registers, unlock sequence, operation sequencing
`default_nettype none
// Functional notes
// - upper byte holds go, permit, error bits
// - lower byte selects operation kind and size
// - key register is write-only guard
// - control write with go accepted only as the transfer right after the key
// - go bit in window starts selected operation
// - go bit settable only, hardware clears
// - operates only with permit; cleared on completion
// - abort by reset pin/watchdog sets error flag
// - decode operation code by erase select
module eepc_top #(
  parameter int OP_CYCLES = eepc_pkg::OP_CYCLES
) (
  input wire logic sys_clk_i, // system clock
  input wire logic reset_i, // synchronous reset, active high
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic external_reset_pin_i, // external reset request, active high
  input wire logic watchdog_timer_i, // watchdog reset request, active high
  output logic op_start_o, // pulse: array operation begins
  output logic [2:0] op_kind_o, // selected operation kind
  output logic op_skip_erase_o, // write without prior erase
  output logic op_busy_o, // array operation running
  output logic irq_o // level interrupt
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [15:0] ctrl;
    eepc_pkg::eepc_unlock_t unlock;
    logic [eepc_pkg::IRQ_W-1:0] status;
    logic [eepc_pkg::IRQ_W-1:0] mask;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic start;
    eepc_pkg::eepc_kind_t kind;
    logic skip;
    logic irq;
  } eepc_state_t;
  eepc_state_t st_reg;
  eepc_state_t st_next;
  logic busy;
  logic done;
  logic abort_req;

  initial
  begin
    if (OP_CYCLES < 1)
      $error("operation cycles must be at least one");
  end

  // decode operation code against erase select
  function automatic eepc_pkg::eepc_kind_t decode_op(input logic [15:0] c);
    eepc_pkg::eepc_kind_t k;
    k = eepc_pkg::EEPC_KIND_NONE;
    if (c[eepc_pkg::BIT_ERASE_SEL])
    begin
      if (c[5:0] == eepc_pkg::OP_ERASE_8)
        k = eepc_pkg::EEPC_KIND_E8;
      else if (c[5:0] == eepc_pkg::OP_ERASE_4)
        k = eepc_pkg::EEPC_KIND_E4;
      else if (c[5:0] == eepc_pkg::OP_ERASE_1)
        k = eepc_pkg::EEPC_KIND_E1;
      else if (c[5:2] == eepc_pkg::OP_ERASE_ALL_HI)
        k = eepc_pkg::EEPC_KIND_EALL;
    end
    else if (c[5:2] == eepc_pkg::OP_WRITE_1_HI)
      k = eepc_pkg::EEPC_KIND_W1;
    return k;
  endfunction

  // ************************************************************
  // next state
  // ************************************************************
  always_comb
  begin
    logic wr_acc;
    logic rd_acc;
    logic ctrl_wr;
    logic go_req;
    logic [15:0] wv;
    logic [eepc_pkg::IRQ_W-1:0] ev;
    eepc_pkg::eepc_kind_t k;
    wr_acc = 1'b0;
    rd_acc = 1'b0;
    ctrl_wr = 1'b0;
    go_req = 1'b0;
    wv = pwdata[15:0];
    ev = '0;
    k = decode_op(st_reg.ctrl);
    st_next = st_reg;
    st_next.ready = 1'b0;
    st_next.err = 1'b0;
    st_next.start = 1'b0;
    // one-cycle answer: ready in the cycle after setup
    if (psel && !penable)
    begin
      st_next.ready = 1'b1;
      st_next.rdata = '0;
    end
    wr_acc = psel && penable && st_reg.ready && pwrite;
    rd_acc = psel && penable && st_reg.ready && !pwrite;
    if (psel && !penable)
    begin
      unique case (paddr)
        eepc_pkg::ADDR_CONTROL: st_next.rdata = {16'h0000, st_reg.ctrl};
        eepc_pkg::ADDR_KEY: st_next.rdata = '0; // write-only, reads zero
        eepc_pkg::ADDR_STATUS: st_next.rdata = {29'h0, st_reg.status};
        eepc_pkg::ADDR_MASK: st_next.rdata = {29'h0, st_reg.mask};
        eepc_pkg::ADDR_ABORT: st_next.rdata = '0;
        default: st_next.err = 1'b1;
      endcase
    end
    // unlock window covers only the very next transfer: lost on a bus gap or at that transfer's access
    if (st_reg.unlock == eepc_pkg::EEPC_OPEN && (!psel || wr_acc || rd_acc))
      st_next.unlock = eepc_pkg::EEPC_IDLE;
    if (wr_acc)
    begin
      unique case (paddr)
        eepc_pkg::ADDR_KEY:
        begin
          // two-step key; anything else returns to idle
          if (st_reg.unlock == eepc_pkg::EEPC_IDLE && pwdata[7:0] == eepc_pkg::KEY_FIRST)
            st_next.unlock = eepc_pkg::EEPC_KEY1;
          else if (st_reg.unlock == eepc_pkg::EEPC_KEY1 && pwdata[7:0] == eepc_pkg::KEY_SECOND)
            st_next.unlock = eepc_pkg::EEPC_OPEN;
          else
            st_next.unlock = eepc_pkg::EEPC_IDLE;
        end
        eepc_pkg::ADDR_CONTROL: ctrl_wr = 1'b1;
        eepc_pkg::ADDR_STATUS: st_next.status = st_reg.status & ~pwdata[eepc_pkg::IRQ_W-1:0];
        eepc_pkg::ADDR_MASK: st_next.mask = pwdata[eepc_pkg::IRQ_W-1:0];
        default: st_next.unlock = st_reg.unlock == eepc_pkg::EEPC_OPEN ? eepc_pkg::EEPC_IDLE : st_reg.unlock;
      endcase
    end
    else if (rd_acc && st_reg.unlock == eepc_pkg::EEPC_KEY1)
      st_next.unlock = eepc_pkg::EEPC_IDLE; // a read between the key writes returns to idle
    // control write: configuration fields only while not busy, go only inside window
    if (ctrl_wr && !busy)
    begin
      st_next.ctrl = (st_reg.ctrl & ~eepc_pkg::CTRL_SW_MASK) | (wv & eepc_pkg::CTRL_SW_MASK);
      st_next.unlock = eepc_pkg::EEPC_IDLE;
      if (wv[eepc_pkg::BIT_GO])
      begin
        if (st_reg.unlock == eepc_pkg::EEPC_OPEN)
          go_req = 1'b1;
        else
          ev[eepc_pkg::IRQ_REJECT] = 1'b1; // stray start ignored
      end
    end
    else if (ctrl_wr && wv[eepc_pkg::BIT_GO])
      ev[eepc_pkg::IRQ_REJECT] = 1'b1;
    // start only with permit and a legal code
    k = decode_op(st_next.ctrl);
    if (go_req && st_next.ctrl[eepc_pkg::BIT_PERMIT] && k != eepc_pkg::EEPC_KIND_NONE)
    begin
      st_next.ctrl[eepc_pkg::BIT_GO] = 1'b1;
      st_next.ctrl[eepc_pkg::BIT_ABORTED] = 1'b0;
      st_next.start = 1'b1;
      st_next.kind = k;
      st_next.skip = st_next.ctrl[eepc_pkg::BIT_SKIP_ERASE];
    end
    else if (go_req)
      ev[eepc_pkg::IRQ_REJECT] = 1'b1;
    // completion: hardware clears go and permit
    if (done)
    begin
      st_next.ctrl[eepc_pkg::BIT_GO] = 1'b0;
      st_next.ctrl[eepc_pkg::BIT_PERMIT] = 1'b0;
      st_next.ctrl[eepc_pkg::BIT_ABORTED] = 1'b0; // success reads zero
      ev[eepc_pkg::IRQ_DONE] = 1'b1;
    end
    // early termination by reset pin or watchdog
    if (abort_req && st_reg.ctrl[eepc_pkg::BIT_GO])
    begin
      st_next.ctrl[eepc_pkg::BIT_GO] = 1'b0;
      st_next.ctrl[eepc_pkg::BIT_PERMIT] = 1'b0;
      st_next.ctrl[eepc_pkg::BIT_ABORTED] = 1'b1;
      st_next.unlock = eepc_pkg::EEPC_IDLE;
      ev[eepc_pkg::IRQ_ABORT] = 1'b1;
    end
    // sticky events: set wins over write-one-clear
    st_next.status = st_next.status | ev;
    st_next.irq = |(st_next.status & st_next.mask);
  end

  assign abort_req = external_reset_pin_i || watchdog_timer_i;

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
    begin
      st_reg <= '0;
      st_reg.ctrl <= eepc_pkg::CTRL_RESET;
      st_reg.unlock <= eepc_pkg::EEPC_IDLE;
      st_reg.kind <= eepc_pkg::EEPC_KIND_NONE;
    end
    else
      st_reg <= st_next;
  end

  // array operation timer
  eepc_cycle_timer #(
    .CYCLES(OP_CYCLES)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .reset_i(reset_i),
    .start_i(st_reg.start),
    .abort_i(abort_req),
    .busy_o(busy),
    .done_o(done)
  );

  // outputs straight from flip-flops
  assign prdata = st_reg.rdata;
  assign pready = st_reg.ready;
  assign pslverr = st_reg.err;
  assign op_start_o = st_reg.start;
  assign op_kind_o = st_reg.kind;
  assign op_skip_erase_o = st_reg.skip;
  assign op_busy_o = busy;
  assign irq_o = st_reg.irq;
endmodule
`default_nettype wire

// ===== eepc_pkg.sv
// package: register map, field layout and timing constants of the eeprom program/erase control
`default_nettype none
package eepc_pkg;
  // ************************************************************
  // register map (apb byte addresses)
  // ************************************************************
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_KEY = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam logic [7:0] ADDR_ABORT = 8'h10;
  // ************************************************************
  // control register fields
  // ************************************************************
  localparam int BIT_GO = 15;
  localparam int BIT_PERMIT = 14;
  localparam int BIT_ABORTED = 13;
  localparam int BIT_SKIP_ERASE = 12;
  localparam int BIT_ERASE_SEL = 6;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CTRL_SW_MASK = 16'h507F; // permit, skip-erase, erase-select, operation code
  localparam logic [5:0] OP_ERASE_8 = 6'h1A;
  localparam logic [5:0] OP_ERASE_4 = 6'h19;
  localparam logic [5:0] OP_ERASE_1 = 6'h18;
  localparam logic [3:0] OP_ERASE_ALL_HI = 4'h4;
  localparam logic [3:0] OP_WRITE_1_HI = 4'h2;
  // ************************************************************
  // key values and status bits
  // ************************************************************
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_ABORT = 1;
  localparam int IRQ_REJECT = 2;
  localparam int IRQ_W = 3;
  // ************************************************************
  // timing: nominal cycle time of one array operation
  // ************************************************************
  localparam int CLK_MHZ = 125;
  localparam int OP_TIME_US = 4;
  localparam int OP_CYCLES = OP_TIME_US * CLK_MHZ;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [1:0] {
    EEPC_IDLE = 2'b00,
    EEPC_KEY1 = 2'b01,
    EEPC_OPEN = 2'b11
  } eepc_unlock_t;
  typedef enum logic [2:0] {
    EEPC_KIND_NONE = 3'h0,
    EEPC_KIND_E1 = 3'h1,
    EEPC_KIND_E4 = 3'h2,
    EEPC_KIND_E8 = 3'h3,
    EEPC_KIND_EALL = 3'h4,
    EEPC_KIND_W1 = 3'h5
  } eepc_kind_t;
  typedef struct packed {
    logic start;
    eepc_kind_t kind;
    logic skip_erase;
  } eepc_op_t;
endpackage
`default_nettype wire

// ===== eepc_cycle_timer.sv
// cycle timer: counts out one array operation and pulses done
`default_nettype none
module eepc_cycle_timer #(
  parameter int CYCLES = eepc_pkg::OP_CYCLES
) (
  input wire logic sys_clk_i, // system clock
  input wire logic reset_i, // synchronous reset
  input wire logic start_i, // begin a timed operation
  input wire logic abort_i, // cancel a running operation
  output logic busy_o, // operation running
  output logic done_o // one-cycle completion pulse
);
  localparam int CW = $clog2(CYCLES + 1);
  typedef struct packed {
    logic [CW-1:0] count;
    logic busy;
    logic done;
  } eepc_tmr_t;
  eepc_tmr_t tmr_reg;
  eepc_tmr_t tmr_next;

  initial
  begin
    if (CYCLES < 1)
      $error("cycle count must be at least one");
  end

  // count down while busy, pulse done at the end
  always_comb
  begin
    tmr_next = tmr_reg;
    tmr_next.done = 1'b0;
    if (abort_i)
    begin
      tmr_next.busy = 1'b0;
      tmr_next.count = '0;
    end
    else if (start_i && !tmr_reg.busy)
    begin
      tmr_next.busy = 1'b1;
      tmr_next.count = CW'(CYCLES - 1);
    end
    else if (tmr_reg.busy)
    begin
      if (tmr_reg.count == '0)
      begin
        tmr_next.busy = 1'b0;
        tmr_next.done = 1'b1;
      end
      else
        tmr_next.count = tmr_reg.count - CW'(1);
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (reset_i)
      tmr_reg <= '0;
    else
      tmr_reg <= tmr_next;
  end

  assign busy_o = tmr_reg.busy;
  assign done_o = tmr_reg.done;
endmodule
`default_nettype wire

// ===== eepc_props.sv
// checker: bus, start, abort and interrupt assertions of the eeprom control block
`default_nettype none
module eepc_props #(
  parameter int OP_CYCLES = eepc_pkg::OP_CYCLES
) (
  input wire logic sys_clk_i, // clock
  input wire logic reset_i, // reset
  input wire logic psel, // select
  input wire logic penable, // enable
  input wire logic pwrite, // direction
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic external_reset_pin_i, // abort source
  input wire logic watchdog_timer_i, // abort source
  input wire logic op_start_o, // start pulse
  input wire logic [2:0] op_kind_o, // kind
  input wire logic op_skip_erase_o, // skip erase
  input wire logic op_busy_o, // busy
  input wire logic irq_o // interrupt
);
  logic [15:0] busy_cnt;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (reset_i);
  // run length of the current operation
  always_ff @(posedge sys_clk_i)
  begin
    busy_cnt <= (reset_i || !op_busy_o) ? 16'h0000 : busy_cnt + 16'h0001;
  end
  // ************************************************************
  // properties
  // ************************************************************
  property p_ready_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_setup: assert property (p_ready_setup) else $error("no ready after setup");
  property p_key_read;
    pready && !pwrite && paddr == eepc_pkg::ADDR_KEY |-> prdata == 32'h0;
  endproperty
  a_key_read: assert property (p_key_read) else $error("key read not zero");
  property p_slverr;
    pready && (paddr > 8'h10 || paddr[1:0] != 2'h0) |-> pslverr;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access not refused");
  property p_start_busy;
    op_start_o |-> ##[0:2] op_busy_o;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start without busy");
  property p_kind;
    op_start_o |-> op_kind_o inside {[3'h1:3'h5]};
  endproperty
  a_kind: assert property (p_kind) else $error("illegal kind at start");
  property p_busy_bound;
    busy_cnt <= 16'(OP_CYCLES + 2);
  endproperty
  a_busy_bound: assert property (p_busy_bound) else $error("operation never ends");
  property p_abort;
    op_busy_o && (external_reset_pin_i || watchdog_timer_i) |-> ##[1:3] !op_busy_o;
  endproperty
  a_abort: assert property (p_abort) else $error("abort did not end operation");
  property p_irq_mask;
    pready && pwrite && paddr == eepc_pkg::ADDR_MASK && pwdata[2:0] == 3'h0 |-> ##2 !irq_o;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked interrupt still high");
  c_start: cover property (op_start_o);
  c_irq: cover property (irq_o);
  c_abort: cover property (op_busy_o && watchdog_timer_i);
endmodule
bind eepc_top eepc_props #(.OP_CYCLES(OP_CYCLES)) u_eepc_props (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .external_reset_pin_i(external_reset_pin_i),
  .watchdog_timer_i(watchdog_timer_i), .op_start_o(op_start_o), .op_kind_o(op_kind_o),
  .op_skip_erase_o(op_skip_erase_o), .op_busy_o(op_busy_o), .irq_o(irq_o));
`default_nettype wire

// ===== eepc_top_test.sv
// testbench: unlock, start, abort and interrupt checks over apb
`default_nettype none
module eepc_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0, reset_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ext = 1'b0, wdt = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, v;
  logic pready, pslverr, start, skip, busy, irq, err, sk;
  logic [2:0] kind, kseen;
  int n_mismatch = 0, check_count = 0, ns = 0, en = 0, seed = 32'h2b6e638c;
  logic [6:0] code [5] = '{7'h5A, 7'h59, 7'h58, 7'h50, 7'h08};
  logic [2:0] kexp [5] = '{3'h3, 3'h2, 3'h1, 3'h4, 3'h5};
  logic [31:0] bad [4] = '{32'hAA55C058, 32'h5554C058, 32'h54AAC058, 32'h55AA8058};
  eepc_top #(.OP_CYCLES(8)) u_eepc_top (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .external_reset_pin_i(ext), .watchdog_timer_i(wdt), .op_start_o(start),
    .op_kind_o(kind), .op_skip_erase_o(skip), .op_busy_o(busy), .irq_o(irq));
  // 125 mhz clock
  initial
  begin
    forever #4 sys_clk_i = ~sys_clk_i;
  end
  // records every operation start
  always @(posedge sys_clk_i)
  begin
    if (start === 1'b1)
    begin
      ns <= ns + 1;
      kseen <= kind;
      sk <= skip;
    end
  end
  // ************************************************************
  // tasks
  // ************************************************************
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic hold);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk_i);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge sys_clk_i);
      i++;
    end
    while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1)
    begin
      n_mismatch++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
    if (!hold)
    begin
      psel <= 1'b0;
      @(posedge sys_clk_i);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rd, exp);
  endtask
  // key pair in the upper half, control word in the lower, back to back
  task automatic go(input logic [31:0] x);
    apb(1'b1, eepc_pkg::ADDR_KEY, {24'h0, x[31:24]}, 1'b1);
    apb(1'b1, eepc_pkg::ADDR_KEY, {24'h0, x[23:16]}, 1'b1);
    apb(1'b1, eepc_pkg::ADDR_CONTROL, {16'h0, x[15:0]}, 1'b0);
  endtask
  task automatic wait_done();
    int i;
    i = 0;
    do
    begin
      @(posedge sys_clk_i);
      i++;
    end
    while ((busy !== 1'b0 || i < 3) && i < 200);
    if (i == 200)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask
  // go and permit clear after completion, flag low
  function automatic logic [31:0] exp_ctrl(input logic [31:0] c);
    return {16'h0, c[15:0] & 16'h107F};
  endfunction
  // ************************************************************
  // main sequence
  // ************************************************************
  initial
  begin
    repeat (6) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    @(posedge sys_clk_i);
    rdc(eepc_pkg::ADDR_CONTROL, 32'h0);
    rdc(eepc_pkg::ADDR_KEY, 32'h0);
    apb(1'b1, eepc_pkg::ADDR_ABORT, $random(seed), 1'b0);
    rdc(eepc_pkg::ADDR_ABORT, 32'h0);
    apb(1'b0, 8'h14, 32'h0, 1'b0);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, eepc_pkg::ADDR_MASK, 32'h7, 1'b0);
    apb(1'b1, eepc_pkg::ADDR_CONTROL, 32'hC058, 1'b0);
    rdc(eepc_pkg::ADDR_CONTROL, 32'h4058);
    for (int i = 0; i < 4; i++)
    begin
      go(bad[i]);
      repeat (3) @(posedge sys_clk_i);
      chk(ns, en);
    end
    @(posedge sys_clk_i);
    chk({31'h0, irq}, 32'h1);
    rdc(eepc_pkg::ADDR_STATUS, 32'h4);
    apb(1'b1, eepc_pkg::ADDR_STATUS, 32'h7, 1'b0);
    @(posedge sys_clk_i);
    chk({31'h0, irq}, 32'h0);
    for (int s = 0; s < 2; s++)
    begin
      go(32'h55AAC050);
      repeat (3) @(posedge sys_clk_i);
      {wdt, ext} <= 2'(s + 1);
      @(posedge sys_clk_i);
      {wdt, ext} <= 2'b00;
      en++;
      wait_done();
      chk(ns, en);
      apb(1'b0, eepc_pkg::ADDR_CONTROL, 32'h0, 1'b0);
      chk(rd & 32'hA000, 32'h2000);
      apb(1'b0, eepc_pkg::ADDR_STATUS, 32'h0, 1'b0);
      chk(rd & 32'h2, 32'h2);
      apb(1'b1, eepc_pkg::ADDR_STATUS, 32'h7, 1'b0);
    end
    for (int i = 0; i < 5; i++)
    begin
      v = {16'h55AA, 3'h6, 1'($random(seed)), 5'h0, code[i] | (i > 2 ? 7'($random(seed)) & 7'h03 : 7'h00)};
      go(v);
      en++;
      wait_done();
      chk(ns, en);
      chk({29'h0, kseen}, {29'h0, kexp[i]});
      chk({31'h0, sk}, {31'h0, v[12]});
      rdc(eepc_pkg::ADDR_CONTROL, exp_ctrl(v));
      rdc(eepc_pkg::ADDR_STATUS, 32'h1);
      apb(1'b1, eepc_pkg::ADDR_STATUS, 32'h1, 1'b0);
    end
    apb(1'b1, eepc_pkg::ADDR_CONTROL, 32'hC058, 1'b0);
    apb(1'b1, eepc_pkg::ADDR_MASK, 32'h0, 1'b0);
    @(posedge sys_clk_i);
    chk({31'h0, irq}, 32'h0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
